// File: bench/wspf_master.sv
`timescale 1ns/100ps
// ============================================================
// bus master model: holds each access until ready, or drops it after 300 clk without ready
// the bus clock stands still low outside a cycle, as a real master would leave it
module wspf_master (
    input  wire logic clk,
    input  wire logic bus_ready,
    input  wire logic go,
    output logic      board_access,
    output logic      bus_clock_inverted,
    output logic      done,
    output int        edges,
    output logic      timed_out
);
    initial begin
        board_access = 1'h0;
        bus_clock_inverted = 1'h0;
        done = 1'h0;
        edges = 0;
        timed_out = 1'h0;
    end

    // first bus clock rise waits 8 clk so selection has settled before counting
    always @(posedge go) begin
        done = 1'h0;
        edges = 0;
        timed_out = 1'h1;
        board_access = 1'h1;
        for (int k = 0; k < 300 && timed_out; k++) begin
            @(negedge clk);
            if (bus_ready === 1'h1) begin
                timed_out = 1'h0;
            end else if (k >= 8 && k % 4 == 0) begin
                bus_clock_inverted = ~bus_clock_inverted;
                if (bus_clock_inverted) begin
                    edges++;
                end
            end
        end
        board_access = 1'h0;
        bus_clock_inverted = 1'h0;
        done = 1'h1;
    end
endmodule : wspf_master

// File: bench/wspf_top_tb.sv
`timescale 1ns/100ps
module wspf_top_tb;
    import wspf_pkg::*;
    typedef struct packed {
        logic [3:0]   sw;
        wspf_status_t st;
        logic [7:0]   bsel;
        logic         ok_n;
        logic [7:0]   cs;
    } wspf_row_t;

    logic       clk = 1'h0, reset = 1'h1, go = 1'h0, board_deselect = 1'h0;
    logic       battery_unused = 1'h1, supply_level_ok = 1'h1;
    logic [3:0] wait_count_switches = 4'h0;
    logic [7:0] block_select_n = 8'hFF;
    logic       board_access, bus_clock_inverted, done, timed_out;
    logic       bus_ready, board_selected, terminal_carry, supply_ok_n;
    logic [3:0] wait_count;
    logic [7:0] chip_select_n;
    int         n_fail = 0, n_compared = 0, edges;
    wspf_row_t  rows [6] = '{'{4'h0, 2'h3, 8'hFE, 1'h0, 8'hFE}, '{4'h5, 2'h3, 8'hA5, 1'h0, 8'hA5},
                             '{4'hE, 2'h2, 8'h00, 1'h1, 8'hFF}, '{4'hF, 2'h1, 8'h7F, 1'h1, 8'hFF},
                             '{4'h9, 2'h0, 8'h00, 1'h1, 8'hFF}, '{4'hA, 2'h3, 8'hFF, 1'h0, 8'hFF}};

    always #25 clk = ~clk;

    wspf_top wspf_top_i (.clk(clk), .reset(reset), .bus_clock_inverted(bus_clock_inverted),
        .board_access(board_access), .board_deselect(board_deselect),
        .wait_count_switches(wait_count_switches), .battery_unused(battery_unused),
        .supply_level_ok(supply_level_ok), .block_select_n(block_select_n), .bus_ready(bus_ready),
        .board_selected(board_selected), .terminal_carry(terminal_carry), .wait_count(wait_count),
        .supply_ok_n(supply_ok_n), .chip_select_n(chip_select_n));

    wspf_master wspf_master_i (.clk(clk), .bus_ready(bus_ready), .go(go), .board_access(board_access),
        .bus_clock_inverted(bus_clock_inverted), .done(done), .edges(edges), .timed_out(timed_out));

    // ============================================================
    // compare and report
    task cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task cmp_vec(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_vec

    task complete_run;
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task run_access;
        @(negedge clk) go = 1'h1;
        for (int k = 0; k < 700; k++) begin
            @(negedge clk);
            if (done) break;
            if (k == 699) begin
                n_fail++;
                complete_run;
            end
        end
        go = 1'h0;
        repeat (8) @(negedge clk);
    endtask : run_access

    // ready stands until the bus clock moves on (a preload of 15 keeps it) or the access ends
    always @(negedge clk) begin
        if (bus_ready === 1'h1) begin
            cmp_vec({4'h0, wait_count}, 8'h0F);
            cmp_bit(terminal_carry, 1'h1);
            cmp_bit(board_selected, 1'h1);
        end
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        cmp_bit(supply_ok_n, 1'h1);
        cmp_vec(chip_select_n, 8'hFF);
        cmp_bit(bus_ready, 1'h0);
        repeat (6) @(negedge clk);
        reset = 1'h0;
        foreach (rows[i]) begin
            wait_count_switches = rows[i].sw;
            battery_unused = rows[i].st.battery_unused;
            supply_level_ok = rows[i].st.supply_level_ok;
            block_select_n = rows[i].bsel;
            repeat (10) @(negedge clk);
            cmp_bit(supply_ok_n, rows[i].ok_n);
            cmp_vec(chip_select_n, rows[i].cs);
            cmp_vec({4'h0, wait_count}, {4'h0, rows[i].sw});
            run_access;
            cmp_bit(timed_out, 1'h0);
            cmp_bit(edges >= 15 - int'(rows[i].sw) && edges <= 16 - int'(rows[i].sw), 1'h1);
        end
        // deselect control wins over an access: the master must never see ready
        board_deselect = 1'h1;
        run_access;
        cmp_bit(timed_out, 1'h1);
        cmp_bit(board_selected, 1'h0);
        // reset in mid-run, then one more access with the last switch setting
        board_deselect = 1'h0;
        reset = 1'h1;
        repeat (2) @(negedge clk);
        cmp_bit(supply_ok_n, 1'h1);
        cmp_vec(chip_select_n, 8'hFF);
        cmp_bit(bus_ready, 1'h0);
        cmp_bit(board_selected, 1'h0);
        cmp_vec({4'h0, wait_count}, 8'h00);
        reset = 1'h0;
        repeat (10) @(negedge clk);
        cmp_vec({4'h0, wait_count}, {4'h0, wait_count_switches});
        run_access;
        cmp_bit(timed_out, 1'h0);
        cmp_bit(edges >= 15 - int'(wait_count_switches) && edges <= 16 - int'(wait_count_switches), 1'h1);
        complete_run;
    end
endmodule : wspf_top_tb

// File: hdl/wspf_gate.sv
`timescale 1ns/100ps
// power-good decision and chip-select gating, registered
module wspf_gate
    import wspf_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset,
    input  wspf_pkg::wspf_status_t status,
    input  wire logic [7:0]   block_select_n,
    output logic              supply_ok_n,
    output logic [7:0]        chip_select_n
);
    import wspf_pkg::*;

    // both status inputs high means supply good; reset holds it failed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            supply_ok_n <= 1'h1;
        end else begin
            supply_ok_n <= ~(status.battery_unused & status.supply_level_ok); // R08 R11
        end
    end

    // gate uses the same decision so selects never pass a failed cycle late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chip_select_n <= WSPF_CS_IDLE;
        end else if (status.battery_unused & status.supply_level_ok) begin
            chip_select_n <= block_select_n; // R07 R09
        end else begin
            chip_select_n <= WSPF_CS_IDLE; // R10
        end
    end

    AST_GATE_BLOCK: assert property (@(posedge clk) disable iff (reset) // R10
        !(status.battery_unused & status.supply_level_ok) |=> chip_select_n == WSPF_CS_IDLE)
        else $error("chip selects not forced high on power fail");
    AST_GATE_PASS: assert property (@(posedge clk) disable iff (reset) // R07
        (status.battery_unused & status.supply_level_ok) |=> chip_select_n == $past(block_select_n))
        else $error("block selects not passed with supply good");
    AST_GATE_PG: assert property (@(posedge clk) disable iff (reset) // R08
        1'h1 |=> supply_ok_n == !($past(status.battery_unused) && $past(status.supply_level_ok)))
        else $error("power-good level wrong");
endmodule : wspf_gate

// File: hdl/wspf_pkg.sv
// How it works
// (R01) while the board is idle the wait counter loads the four switch bits, bit 0 lsb
// (R02) once the board is selected the counter counts one per bus clock edge
// (R03) terminal carry is asserted when the counter value reaches 15
// (R04) terminal carry is captured in a flip-flop that reloads the switch value
// (R05) bus ready equals terminal carry and board selected
// (R06) delay is whole bus clocks, set by the preload value
// (R07) with supply good the eight block selects pass unchanged to the chip selects
// (R08) power-good low only when battery unused and supply above threshold both high
// (R09) chip selects rest high unless their block select is low
// (R10) power-good inactive forces all eight chip selects high
// (R11) supply-level input low means supply below about 4.75 V, power-good goes inactive
// (R12) board-deselect control bit set to one forces board selected inactive
// (R13) bus master holds the cycle with wait states until bus ready
package wspf_pkg;
    // ==========================================================
    // widths and constants
    localparam int         WSPF_CNT_W      = 4;
    localparam int         WSPF_BLOCKS     = 8;
    localparam logic [3:0] WSPF_CNT_TERM   = 4'hF;
    localparam logic [3:0] WSPF_CNT_STEP   = 4'h1;
    localparam logic [3:0] WSPF_CNT_RESET  = 4'h0;
    localparam logic [7:0] WSPF_CS_IDLE    = 8'hFF;
    localparam logic [2:0] WSPF_SYNC_RESET = 3'h0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic battery_unused;
        logic supply_level_ok;
    } wspf_status_t;

    typedef enum logic [2:0] {
        WSPF_IDLE  = 3'h1,
        WSPF_COUNT = 3'h2,
        WSPF_DONE  = 3'h4
    } wspf_state_t;
endpackage : wspf_pkg

// File: hdl/wspf_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output changes only when stages two and three agree
module wspf_sync
    import wspf_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    import wspf_pkg::*;

    logic [2:0] stage;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage <= WSPF_SYNC_RESET;
        end else begin
            stage <= {stage[1:0], din};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dout <= 1'h0;
        end else if (stage[1] == stage[2]) begin
            dout <= stage[2];
        end
    end
endmodule : wspf_sync

// File: hdl/wspf_top.sv
`timescale 1ns/100ps
// wait-state generator plus power-fail chip-select gate
module wspf_top
    import wspf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       bus_clock_inverted,
    input  wire logic       board_access,
    input  wire logic       board_deselect,
    input  wire logic [3:0] wait_count_switches,
    input  wire logic       battery_unused,
    input  wire logic       supply_level_ok,
    input  wire logic [7:0] block_select_n,
    output logic            bus_ready,
    output logic            board_selected,
    output logic            terminal_carry,
    output logic [3:0]      wait_count,
    output logic            supply_ok_n,
    output logic [7:0]      chip_select_n
);
    import wspf_pkg::*;

    // ==========================================================
    // input synchronisers
    logic         bclk_s;
    logic         access_s;
    logic         batt_s;
    logic         level_s;
    logic [3:0]   sw_s;
    logic         bclk_d;
    logic         bclk_edge;
    logic         sel;
    logic         rco_hold;
    logic         next_rco;
    logic [3:0]   next_cnt;
    wspf_state_t  state;
    wspf_status_t status;

    function automatic logic is_term(input logic [3:0] v);
        return v == WSPF_CNT_TERM;
    endfunction : is_term

    wspf_sync u_sync_bclk (.clk(clk), .reset(reset), .din(bus_clock_inverted), .dout(bclk_s));
    wspf_sync u_sync_acc  (.clk(clk), .reset(reset), .din(board_access),       .dout(access_s));
    wspf_sync u_sync_batt (.clk(clk), .reset(reset), .din(battery_unused),     .dout(batt_s));
    wspf_sync u_sync_lvl  (.clk(clk), .reset(reset), .din(supply_level_ok),    .dout(level_s));

    genvar gi;
    generate
        for (gi = 0; gi < WSPF_CNT_W; gi++) begin : g_sw
            wspf_sync u_sync_sw (.clk(clk), .reset(reset), .din(wait_count_switches[gi]), .dout(sw_s[gi]));
        end
    endgenerate

    // ==========================================================
    // board select and bus clock edge
    // deselect bit is a same-clock control input, used unsynchronised
    assign sel = access_s & ~board_deselect; // R12

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bclk_d <= 1'h0;
        end else begin
            bclk_d <= bclk_s;
        end
    end

    // only a leading edge of the inverted bus clock advances the count
    assign bclk_edge = bclk_s & ~bclk_d; // R06

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            board_selected <= 1'h0;
        end else begin
            board_selected <= sel;
        end
    end

    // ==========================================================
    // wait counter
    // the carry is held one clk and then reloads the switches; a preload of 15
    // therefore answers at once, and the wait never runs past 16 bus clocks
    always_comb begin
        next_cnt = wait_count;
        next_rco = rco_hold;
        if (!sel || rco_hold) begin
            next_cnt = sw_s; // R01 R04
            next_rco = 1'h0;
        end else if (bclk_edge) begin
            if (is_term(wait_count)) begin
                next_rco = 1'h1; // R04
            end else begin
                next_cnt = wait_count + WSPF_CNT_STEP; // R02
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_count <= WSPF_CNT_RESET;
        end else begin
            wait_count <= next_cnt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rco_hold <= 1'h0;
        end else begin
            rco_hold <= next_rco;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            terminal_carry <= 1'h0;
        end else begin
            terminal_carry <= sel & is_term(next_cnt); // R03
        end
    end

    // ready held until the carry reloads the switches after the next bus clock edge (a preload of 15 keeps it), or the access ends (master waits for it)
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_ready <= 1'h0;
        end else begin
            bus_ready <= sel & is_term(next_cnt); // R05 R13
        end
    end

    // ==========================================================
    // access sequencing, for observation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= WSPF_IDLE;
        end else begin
            // done tracks ready exactly, also for a preload of 15 and after a reload
            case (state)
                WSPF_IDLE: begin
                    if (sel && is_term(next_cnt)) begin
                        state <= WSPF_DONE;
                    end else if (sel) begin
                        state <= WSPF_COUNT;
                    end
                end
                WSPF_COUNT: begin
                    if (!sel) begin
                        state <= WSPF_IDLE;
                    end else if (is_term(next_cnt)) begin
                        state <= WSPF_DONE;
                    end
                end
                WSPF_DONE: begin
                    if (!sel) begin
                        state <= WSPF_IDLE;
                    end else if (!is_term(next_cnt)) begin
                        state <= WSPF_COUNT;
                    end
                end
                default: begin
                    state <= WSPF_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // power-fail gate
    assign status.battery_unused  = batt_s;
    assign status.supply_level_ok = level_s;

    wspf_gate u_gate (
        .clk            (clk),
        .reset          (reset),
        .status         (status),
        .block_select_n (block_select_n),
        .supply_ok_n    (supply_ok_n),
        .chip_select_n  (chip_select_n)
    );

    // ==========================================================
    // checks
    // named steps of one access, so each property reads as one rule
    sequence s_idle_load;
        !sel ##1 1'h1;
    endsequence

    sequence s_count_step;
        sel && !rco_hold && bclk_edge && !is_term(wait_count);
    endsequence

    sequence s_count_hold;
        sel && !rco_hold && !bclk_edge;
    endsequence

    sequence s_carry_catch;
        sel && !rco_hold && bclk_edge && is_term(wait_count);
    endsequence

    AST_LOAD: assert property (@(posedge clk) disable iff (reset) // R01
        s_idle_load |-> wait_count == $past(sw_s))
        else $error("counter not loaded while idle");
    AST_COUNT: assert property (@(posedge clk) disable iff (reset) // R02
        s_count_step |=> wait_count == $past(wait_count) + WSPF_CNT_STEP)
        else $error("counter did not step on bus clock edge");
    AST_HOLD: assert property (@(posedge clk) disable iff (reset) // R06
        s_count_hold |=> wait_count == $past(wait_count))
        else $error("counter moved without bus clock edge");
    AST_TERM: assert property (@(posedge clk) disable iff (reset) // R03
        terminal_carry |-> wait_count == WSPF_CNT_TERM)
        else $error("terminal carry without count 15");
    AST_CATCH: assert property (@(posedge clk) disable iff (reset) // R04
        s_carry_catch |=> rco_hold)
        else $error("carry not captured at count 15");
    AST_RELOAD: assert property (@(posedge clk) disable iff (reset) // R04
        rco_hold |=> wait_count == $past(sw_s))
        else $error("carry did not reload counter");
    AST_READY: assert property (@(posedge clk) disable iff (reset) // R05
        bus_ready |-> terminal_carry && board_selected)
        else $error("ready without carry and select");
    AST_CARRY_READY: assert property (@(posedge clk) disable iff (reset) // R05
        1'h1 |-> terminal_carry == bus_ready)
        else $error("carry and ready disagree");
    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (reset) // R05
        !sel |=> !bus_ready && !terminal_carry)
        else $error("ready while the board is not selected");
    AST_SEL_FOLLOW: assert property (@(posedge clk) disable iff (reset) // R02
        1'h1 |=> board_selected == $past(sel))
        else $error("board selected does not follow the access");
    AST_EDGE_SINGLE: assert property (@(posedge clk) disable iff (reset) // R06
        bclk_edge |=> !bclk_edge)
        else $error("one bus clock edge counted twice");
    AST_STATE_DONE: assert property (@(posedge clk) disable iff (reset) // R05
        bus_ready |-> state == WSPF_DONE)
        else $error("ready outside the done state");
    AST_STATE_READY: assert property (@(posedge clk) disable iff (reset) // R05
        state == WSPF_DONE |-> bus_ready)
        else $error("done state without ready");
    AST_STATE_IDLE: assert property (@(posedge clk) disable iff (reset) // R01
        !board_selected |-> state == WSPF_IDLE)
        else $error("sequencer busy while board not selected");
    AST_STATE_ONEHOT: assert property (@(posedge clk) disable iff (reset) // R02
        $onehot(state))
        else $error("sequencer state not one-hot");
    AST_DESEL: assert property (@(posedge clk) disable iff (reset) // R12
        board_deselect |=> !board_selected && !bus_ready)
        else $error("deselect bit did not block the board");
endmodule : wspf_top
